// *** core/mbl_link_slave.sv ***
// link layer slave: uart framing, frame parse, ack and response reply
//
// Overview of operation
// - start, eight data, even parity, stop
// - telegram characters sent without gaps
// - data bits least significant first
// - half duplex, bit rate configurable
// - acknowledge is single character e5
// - short frame: 10, c, a, cs, 16
// - long frame layout with 0..252 user bytes
// - checksum is modulo-256 sum c..data
// - length equals user bytes plus three
// - control byte direction, fcb/fcv, function
// - retries repeat reply unchanged
// - ignore fcb when fcv is zero
// - control codes for nke, ud, req, rsp
// - addresses 1..250, unconfigured answers 0
// - 255 silent, 254 reply own address
// - 253 answers when secondary selected
// - ci mode bit flags msb-first order
// - nke resets fcb expectation to one
// - nke answered with acknowledge
// - good snd_ud acknowledged, bad silent
// - req_ud2 answered with rsp_ud long frame
`timescale 1ns/100ps
`include "mbl_defines.svh"
module mbl_link_slave #(
	parameter int CLK_HZ = `MBL_CLK_HZ,
	parameter int BAUD = 2400,
	parameter int DEPTH = `MBL_BUF_DEPTH
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// serial line
	input wire logic rxd,
	output logic txd,
	output logic tx_busy,
	// configuration
	input wire logic [7:0] own_addr,
	input wire logic sec_selected,
	// reply user data source, written before a request
	input wire logic [7:0] rsp_len,
	input wire logic rsp_wr,
	input wire logic [7:0] rsp_wr_addr,
	input wire logic [7:0] rsp_wr_data,
	input wire logic [7:0] rsp_ci,
	input wire logic rsp_next,
	// received telegram events
	output logic rx_frame,
	output logic [7:0] rx_c,
	output logic [7:0] rx_ci,
	output logic [7:0] rx_nbytes,
	output logic rx_mode_msb,
	output logic rx_err,
	output logic nke_seen,
	output logic fcb_expect,
	output logic rsp_is_repeat,
	// received user data stream
	output logic rx_data_vld,
	output logic [7:0] rx_data
);
	import mbl_pkg::*;

	// ============================================================
	// bit timing
	localparam int BIT_CYC = CLK_HZ / BAUD;
	localparam int HALF_CYC = BIT_CYC / 2;
	localparam int CW = $clog2(BIT_CYC + 1);

	function automatic logic par_even(input logic [7:0] d);
		par_even = ^d;
	endfunction

	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] own, input logic sel);
		// 255 and 254 reach everyone, 253 only the selected slave
		addr_hit = (a == own) || (a == `MBL_ADDR_BCAST) || (a == `MBL_ADDR_TEST) ||
			((a == `MBL_ADDR_SEL) && sel);
	endfunction

	// ============================================================
	// receiver: two-flop sync then character framing
	logic rx_s1_reg, rx_s2_reg; // only s2 is read by logic
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
		end else begin
			rx_s1_reg <= rxd;
			rx_s2_reg <= rx_s1_reg;
		end
	end

	logic [CW-1:0] rcnt_reg; // bit timer
	logic [3:0] rbit_reg; // 0 start, 1..8 data, 9 parity, 10 stop
	logic rbusy_reg;
	logic [7:0] rsh_reg; // data shift, lsb arrives first
	logic rpar_reg;
	logic chr_vld; // one-cycle character strobe
	logic chr_perr;
	logic [7:0] chr;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rcnt_reg <= '0;
			rbit_reg <= '0;
			rbusy_reg <= 1'b0;
			rsh_reg <= 8'h00;
			rpar_reg <= 1'b0;
			chr_vld <= 1'b0;
			chr_perr <= 1'b0;
			chr <= 8'h00;
		end else begin
			chr_vld <= 1'b0;
			if (!rbusy_reg) begin
				// idle line is mark; a space starts a character
				if (!rx_s2_reg && !tx_busy) begin
					rbusy_reg <= 1'b1;
					rcnt_reg <= CW'(HALF_CYC);
					rbit_reg <= '0;
				end
			end else if (rcnt_reg != '0) begin
				rcnt_reg <= rcnt_reg - 1'b1;
			end else begin
				rcnt_reg <= CW'(BIT_CYC - 1);
				rbit_reg <= rbit_reg + 1'b1;
				if (rbit_reg == 4'd0) begin
					// a glitch, not a real start bit
					if (rx_s2_reg) rbusy_reg <= 1'b0;
				end else if (rbit_reg <= 4'd8) begin
					rsh_reg <= {rx_s2_reg, rsh_reg[7:1]};
				end else if (rbit_reg == 4'd9) begin
					rpar_reg <= rx_s2_reg;
				end else begin
					// stop bit: a space here is a framing fault
					rbusy_reg <= 1'b0;
					chr_vld <= 1'b1;
					chr <= rsh_reg;
					chr_perr <= (par_even(rsh_reg) != rpar_reg) || !rx_s2_reg;
				end
			end
		end
	end

	// ============================================================
	// frame parser
	mbl_rx_e rx_st_reg;
	logic [7:0] len_reg, cnt_reg, sum_reg, c_reg, a_reg, ci_reg;
	logic bad_reg, long_reg;
	logic frm_ok; // one-cycle: good frame addressed here
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_st_reg <= MBL_RX_IDLE;
			len_reg <= 8'h00;
			cnt_reg <= 8'h00;
			sum_reg <= 8'h00;
			c_reg <= 8'h00;
			a_reg <= 8'h00;
			ci_reg <= 8'h00;
			bad_reg <= 1'b0;
			long_reg <= 1'b0;
			frm_ok <= 1'b0;
			rx_err <= 1'b0;
			rx_data_vld <= 1'b0;
			rx_data <= 8'h00;
		end else begin
			frm_ok <= 1'b0;
			rx_err <= 1'b0;
			rx_data_vld <= 1'b0;
			if (chr_vld) begin
				if (chr_perr && rx_st_reg != MBL_RX_IDLE) bad_reg <= 1'b1;
				unique case (rx_st_reg)
					MBL_RX_IDLE: begin
						bad_reg <= chr_perr;
						sum_reg <= 8'h00;
						if (chr == `MBL_SHORT_START) begin
							long_reg <= 1'b0;
							rx_st_reg <= MBL_RX_C;
						end else if (chr == `MBL_LONG_START) begin
							long_reg <= 1'b1;
							rx_st_reg <= MBL_RX_L1;
						end else begin
							// stray characters (including echoed acks) are dropped
							rx_st_reg <= MBL_RX_IDLE;
						end
					end
					MBL_RX_L1: begin
						len_reg <= chr;
						if (chr < `MBL_L_OVERHEAD) bad_reg <= 1'b1;
						rx_st_reg <= MBL_RX_L2;
					end
					MBL_RX_L2: begin
						if (chr != len_reg) bad_reg <= 1'b1;
						rx_st_reg <= MBL_RX_S2;
					end
					MBL_RX_S2: begin
						if (chr != `MBL_LONG_START) bad_reg <= 1'b1;
						rx_st_reg <= MBL_RX_C;
					end
					MBL_RX_C: begin
						c_reg <= chr;
						sum_reg <= chr;
						rx_st_reg <= MBL_RX_A;
					end
					MBL_RX_A: begin
						a_reg <= chr;
						sum_reg <= sum_reg + chr;
						cnt_reg <= len_reg - `MBL_L_OVERHEAD;
						rx_st_reg <= long_reg ? MBL_RX_CI : MBL_RX_CS;
					end
					MBL_RX_CI: begin
						ci_reg <= chr;
						sum_reg <= sum_reg + chr;
						rx_st_reg <= (cnt_reg == 8'h00) ? MBL_RX_CS : MBL_RX_DATA;
					end
					MBL_RX_DATA: begin
						sum_reg <= sum_reg + chr;
						cnt_reg <= cnt_reg - 1'b1;
						rx_data_vld <= addr_hit(a_reg, own_addr, sec_selected);
						rx_data <= chr;
						if (cnt_reg == 8'h01) rx_st_reg <= MBL_RX_CS;
					end
					MBL_RX_CS: begin
						if (chr != sum_reg) bad_reg <= 1'b1;
						rx_st_reg <= MBL_RX_STOP;
					end
					MBL_RX_STOP: begin
						rx_st_reg <= MBL_RX_IDLE;
						// the direction bit must say master-to-slave
						if (bad_reg || chr_perr || chr != `MBL_STOP_CHAR || c_reg[7] ||
							!c_reg[`MBL_C_DIR_BIT]) begin
							rx_err <= 1'b1;
						end else if (addr_hit(a_reg, own_addr, sec_selected)) begin
							frm_ok <= 1'b1;
						end
					end
					default: rx_st_reg <= MBL_RX_IDLE;
				endcase
			end
		end
	end

	// ============================================================
	// received-frame report to the user side
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_frame <= 1'b0;
			rx_c <= 8'h00;
			rx_ci <= 8'h00;
			rx_nbytes <= 8'h00;
			rx_mode_msb <= 1'b0;
		end else begin
			rx_frame <= frm_ok;
			if (frm_ok) begin
				rx_c <= c_reg;
				rx_ci <= long_reg ? ci_reg : 8'h00;
				rx_nbytes <= long_reg ? (len_reg - `MBL_L_OVERHEAD) : 8'h00;
				rx_mode_msb <= long_reg & ci_reg[`MBL_CI_MODE_BIT];
			end
		end
	end

	// ============================================================
	// reply decision and frame count bookkeeping
	logic is_nke, is_ud, is_req2, fcv, fcb, retry;
	assign is_nke = !long_reg && c_reg == `MBL_C_NKE;
	assign is_ud = long_reg && c_reg[3:0] == `MBL_C_SND_UD;
	assign is_req2 = !long_reg && c_reg[3:0] == `MBL_C_REQ_UD2;
	assign fcv = c_reg[`MBL_C_FCV_BIT];
	assign fcb = c_reg[`MBL_C_FCB_BIT];
	// a retry keeps the old fcb; fcv low means never a retry
	assign retry = fcv && (fcb != fcb_expect);

	mbl_rep_e rep_req; // one-cycle reply request
	logic snap_reg; // reply data frozen for the next response
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rep_req <= MBL_REP_NONE;
			fcb_expect <= 1'b1;
			nke_seen <= 1'b0;
			rsp_is_repeat <= 1'b0;
		end else begin
			rep_req <= MBL_REP_NONE;
			nke_seen <= 1'b0;
			if (frm_ok) begin
				if (is_nke) begin
					fcb_expect <= 1'b1;
					nke_seen <= 1'b1;
				end else if (fcv && !retry) begin
					fcb_expect <= ~fcb_expect;
				end
				// broadcast 255 is taken but never answered
				if (a_reg != `MBL_ADDR_BCAST) begin
					if (is_nke || is_ud) rep_req <= MBL_REP_ACK;
					else if (is_req2) rep_req <= MBL_REP_RSP;
				end
				if (is_req2) rsp_is_repeat <= retry;
			end
		end
	end

	// ============================================================
	// reply buffer: user writes here, repeats resend it unchanged
	logic [7:0] buf_mem [DEPTH];
	logic [7:0] rd_data;
	logic [7:0] tlen_reg, tci_reg;
	always_ff @(posedge ref_clk) begin
		if (rsp_wr) buf_mem[rsp_wr_addr] <= rsp_wr_data;
	end
	// length and ci latched per fresh response, and for a repeat while no snapshot is held yet
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tlen_reg <= 8'h00;
			tci_reg <= 8'h00;
			snap_reg <= 1'b0;
		end else begin
			if (rsp_next) snap_reg <= 1'b1;
			if (rep_req == MBL_REP_RSP && (!rsp_is_repeat || !snap_reg)) begin
				tlen_reg <= (rsp_len > `MBL_MAX_USER) ? `MBL_MAX_USER : rsp_len;
				tci_reg <= rsp_ci;
				snap_reg <= 1'b1;
			end
		end
	end

	// ============================================================
	// transmitter sequencer and serializer
	mbl_tx_e tx_st_reg;
	logic [2:0] hidx_reg; // header position 0..6
	logic [7:0] bidx_reg, tsum_reg;
	logic [10:0] tsh_reg; // start, data, parity, stop
	logic [3:0] tbits_reg;
	logic [CW-1:0] tcnt_reg;
	logic tload; // serializer free: idle, or in the last cycle of its stop bit
	logic [7:0] tbyte;
	logic tgo;
	// freeing the serializer one stop-bit cycle early lets the next start bit follow without a stretched stop
	assign tload = (tbits_reg == 4'd0) || (tbits_reg == 4'd1 && tcnt_reg == '0);
	assign rd_data = buf_mem[bidx_reg];
	// own address even when called through 254
	always_comb begin
		tbyte = 8'h00;
		tgo = 1'b0;
		unique case (tx_st_reg)
			MBL_TX_IDLE: begin
				tgo = 1'b0;
			end
			MBL_TX_HDR: begin
				tgo = 1'b1;
				unique case (hidx_reg)
					3'd0, 3'd3: tbyte = `MBL_LONG_START;
					3'd1, 3'd2: tbyte = tlen_reg + `MBL_L_OVERHEAD;
					3'd4: tbyte = `MBL_C_RSP_UD;
					3'd5: tbyte = own_addr;
					default: tbyte = tci_reg;
				endcase
			end
			MBL_TX_BODY: begin
				tgo = 1'b1;
				tbyte = rd_data;
			end
			MBL_TX_CS: begin
				tgo = 1'b1;
				tbyte = tsum_reg;
			end
			MBL_TX_END: begin
				tgo = 1'b1;
				tbyte = `MBL_STOP_CHAR;
			end
		endcase
	end

	logic ack_pend_reg;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tx_st_reg <= MBL_TX_IDLE;
			hidx_reg <= '0;
			bidx_reg <= 8'h00;
			tsum_reg <= 8'h00;
			ack_pend_reg <= 1'b0;
		end else begin
			unique case (tx_st_reg)
				MBL_TX_IDLE: begin
					hidx_reg <= '0;
					bidx_reg <= 8'h00;
					tsum_reg <= 8'h00;
					if (rep_req == MBL_REP_ACK) ack_pend_reg <= 1'b1;
					else if (rep_req == MBL_REP_RSP) tx_st_reg <= MBL_TX_HDR;
					if (ack_pend_reg && tload) ack_pend_reg <= 1'b0;
				end
				MBL_TX_HDR: if (tload) begin
					if (hidx_reg >= 3'd4) tsum_reg <= tsum_reg + tbyte;
					hidx_reg <= hidx_reg + 1'b1;
					if (hidx_reg == 3'd6) tx_st_reg <= (tlen_reg == 8'h00) ? MBL_TX_CS : MBL_TX_BODY;
				end
				MBL_TX_BODY: if (tload) begin
					tsum_reg <= tsum_reg + tbyte;
					bidx_reg <= bidx_reg + 1'b1;
					if (bidx_reg == tlen_reg - 1'b1) tx_st_reg <= MBL_TX_CS;
				end
				MBL_TX_CS: if (tload) tx_st_reg <= MBL_TX_END;
				MBL_TX_END: if (tload) tx_st_reg <= MBL_TX_IDLE;
				default: tx_st_reg <= MBL_TX_IDLE;
			endcase
		end
	end

	// serializer reloads in the cycle its stop bit ends, so no gap
	logic [7:0] load_byte;
	logic load_now;
	assign load_now = tload && (tgo || (ack_pend_reg && tx_st_reg == MBL_TX_IDLE));
	assign load_byte = tgo ? tbyte : `MBL_ACK_CHAR;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tsh_reg <= 11'h7ff;
			tbits_reg <= 4'd0;
			tcnt_reg <= '0;
			txd <= 1'b1;
		end else if (load_now) begin
			tsh_reg <= {1'b1, par_even(load_byte), load_byte, 1'b0};
			tbits_reg <= 4'd11;
			tcnt_reg <= CW'(BIT_CYC - 1);
			txd <= 1'b0;
		end else if (!tload) begin
			if (tcnt_reg != '0) begin
				tcnt_reg <= tcnt_reg - 1'b1;
			end else begin
				tcnt_reg <= CW'(BIT_CYC - 1);
				tsh_reg <= {1'b1, tsh_reg[10:1]};
				tbits_reg <= tbits_reg - 1'b1;
				txd <= tsh_reg[1]; // the stop mark shifts out last
			end
		end
	end
	// receiver is blind while busy, half duplex
	assign tx_busy = !tload || tx_st_reg != MBL_TX_IDLE || ack_pend_reg || rep_req != MBL_REP_NONE;

	// ============================================================
	// checks
	a_idle_mark: assert property (@(posedge ref_clk) disable iff (rst)
		!tx_busy |-> txd) else $error("line not at mark while idle");
	a_bcast_silent: assert property (@(posedge ref_clk) disable iff (rst)
		(frm_ok && a_reg == `MBL_ADDR_BCAST) |=> rep_req == MBL_REP_NONE)
		else $error("broadcast answered");
	a_nke_ack: assert property (@(posedge ref_clk) disable iff (rst)
		(frm_ok && is_nke && a_reg != `MBL_ADDR_BCAST) |=> rep_req == MBL_REP_ACK)
		else $error("nke not acknowledged");
	a_ud_ack: assert property (@(posedge ref_clk) disable iff (rst)
		(frm_ok && is_ud && a_reg != `MBL_ADDR_BCAST) |=> rep_req == MBL_REP_ACK)
		else $error("snd_ud not acknowledged");
	a_req_rsp: assert property (@(posedge ref_clk) disable iff (rst)
		(frm_ok && is_req2 && a_reg != `MBL_ADDR_BCAST) |=> rep_req == MBL_REP_RSP)
		else $error("req_ud2 not answered");
	a_err_silent: assert property (@(posedge ref_clk) disable iff (rst)
		rx_err |=> !rx_frame && rep_req == MBL_REP_NONE) else $error("bad frame accepted");
	a_nke_fcb: assert property (@(posedge ref_clk) disable iff (rst)
		(frm_ok && is_nke) |=> fcb_expect) else $error("fcb not resynced");
	a_fcv_ignore: assert property (@(posedge ref_clk) disable iff (rst)
		(frm_ok && !fcv && !is_nke) |=> $stable(fcb_expect)) else $error("fcb used without fcv");
	a_start_space: assert property (@(posedge ref_clk) disable iff (rst)
		load_now |=> !txd [*8]) else $error("start bit not space");
	c_ack_sent: cover property (@(posedge ref_clk) disable iff (rst) rep_req == MBL_REP_ACK);
	c_rsp_sent: cover property (@(posedge ref_clk) disable iff (rst) tx_st_reg == MBL_TX_END);
	c_rx_err: cover property (@(posedge ref_clk) disable iff (rst) rx_err);
	c_repeat: cover property (@(posedge ref_clk) disable iff (rst) frm_ok && is_req2 && retry);
endmodule

// *** core/mbl_defines.svh ***
// constants for the bus link layer slave
`ifndef MBL_DEFINES_SVH
`define MBL_DEFINES_SVH
`define MBL_CLK_HZ 100000000
`define MBL_BAUD_MIN 300
`define MBL_ACK_CHAR 8'he5
`define MBL_SHORT_START 8'h10
`define MBL_LONG_START 8'h68
`define MBL_STOP_CHAR 8'h16
`define MBL_C_NKE 8'h40
`define MBL_C_SND_UD 4'h3
`define MBL_C_REQ_UD2 4'hb
`define MBL_C_REQ_UD1 4'ha
`define MBL_C_RSP_UD 8'h08
`define MBL_C_DIR_BIT 6
`define MBL_C_FCB_BIT 5
`define MBL_C_FCV_BIT 4
`define MBL_CI_MODE_BIT 2
`define MBL_ADDR_MAX 8'hfa
`define MBL_ADDR_SEL 8'hfd
`define MBL_ADDR_TEST 8'hfe
`define MBL_ADDR_BCAST 8'hff
`define MBL_L_OVERHEAD 8'h03
`define MBL_MAX_USER 8'hfc
`define MBL_BUF_DEPTH 256
`endif

// *** core/mbl_pkg.sv ***
// types for the bus link layer slave
package mbl_pkg;
	typedef enum logic [3:0] {
		MBL_RX_IDLE, MBL_RX_L1, MBL_RX_L2, MBL_RX_S2, MBL_RX_C, MBL_RX_A,
		MBL_RX_CI, MBL_RX_DATA, MBL_RX_CS, MBL_RX_STOP
	} mbl_rx_e;
	typedef enum logic [1:0] {MBL_REP_NONE, MBL_REP_ACK, MBL_REP_RSP} mbl_rep_e;
	typedef enum logic [2:0] {
		MBL_TX_IDLE, MBL_TX_HDR, MBL_TX_BODY, MBL_TX_CS, MBL_TX_END
	} mbl_tx_e;
endpackage

// *** tb/mbl_master_model.sv ***
// behavioural bus master: sends telegrams on the slave's rxd and collects replies from its txd
`timescale 1ns/100ps
module mbl_master_model #(
	parameter int BIT = 10
) (
	// clock
	input wire logic ref_clk,
	// serial line seen from the master side
	input wire logic txd,
	output logic rxd
);
	// ==========================================
	// line state and fault count
	int errs = 0; // malformed characters seen in replies
	initial rxd = 1'b1; // idle line rests at mark

	// step to just after a rising edge, so drives never race the slave's sampling
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// ==========================================
	// transmit
	// one character: space start, data lsb first, even parity, mark stop
	task automatic put(input logic [7:0] b, input bit bad);
		logic [10:0] f;
		f = {1'b1, ^b ^ bad, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rxd = f[i];
			tick(BIT); // next start follows the stop bit directly
		end
	endtask

	// whole telegram; bad_idx names a character sent with wrong parity
	task automatic send(input logic [7:0] q[$], input int bad_idx);
		tick(1);
		foreach (q[i]) put(q[i], i == bad_idx);
		rxd = 1'b1;
	endtask

	// ==========================================
	// receive
	// a gap longer than half a bit ends the telegram, so a gappy reply shows up split
	task automatic recv(output logic [7:0] q[$]);
		logic [10:0] f;
		int n;
		q = {};
		n = 0;
		while (txd !== 1'b0 && n < 60 * BIT) begin
			tick(1);
			n++;
		end
		while (txd === 1'b0) begin
			tick(BIT / 2);
			for (int i = 0; i < 11; i++) begin
				f[i] = txd;
				if (i < 10) tick(BIT);
			end
			if (f[0] !== 1'b0 || f[10] !== 1'b1 || ^f[9:1] !== 1'b0) errs++;
			q.push_back(f[8:1]);
			n = 0;
			while (txd !== 1'b0 && n < BIT) begin
				tick(1);
				n++;
			end
		end
	endtask
endmodule

// *** tb/tb.sv ***
// self-checking bench for the link layer slave driven through a master model
`timescale 1ns/100ps
module tb;
	// ==========================================
	// signals
	typedef logic [7:0] mbl_bq_t[$];
	localparam int BIT = 10; // clocks per bit at 10 Mbaud
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic rxd, txd, tx_busy, sec_selected, rsp_wr;
	logic [7:0] own_addr, rsp_len, rsp_wr_addr, rsp_wr_data, rsp_ci;
	logic rx_frame, rx_mode_msb, rx_err, nke_seen, fcb_expect, rsp_is_repeat, rx_data_vld;
	logic [7:0] rx_c, rx_ci, rx_nbytes, rx_data;
	logic got_frame, got_err, got_nke; // sticky copies of the one-cycle pulses
	logic clr_caps = 1'b0; // empties the sticky copies at the next edge
	mbl_bq_t rxq, r, rsp, d, q, none;
	int checks = 0;
	int fails = 0;
	// address cases: addr, selected, reply expected, frame accepted
	logic [10:0] atab [5] = '{{8'h07, 3'b000}, {8'hff, 3'b001}, {8'hfe, 3'b011}, {8'hfd, 3'b111},
		{8'hfd, 3'b000}};

	always #5 ref_clk = ~ref_clk;

	// catch pulses and the user byte stream
	// this process alone writes the copies, so a clear never races a pulse
	always @(posedge ref_clk) begin
		if (clr_caps) begin
			got_frame <= 1'b0;
			got_err <= 1'b0;
			got_nke <= 1'b0;
			rxq.delete();
		end else begin
			if (rx_frame === 1'b1) got_frame <= 1'b1;
			if (rx_err === 1'b1) got_err <= 1'b1;
			if (nke_seen === 1'b1) got_nke <= 1'b1;
			if (rx_data_vld === 1'b1) rxq.push_back(rx_data);
		end
	end

	mbl_link_slave #(.CLK_HZ(100000000), .BAUD(10000000)) DUT (
		.ref_clk(ref_clk), .rst(rst), .rxd(rxd), .txd(txd), .tx_busy(tx_busy),
		.own_addr(own_addr), .sec_selected(sec_selected), .rsp_len(rsp_len), .rsp_wr(rsp_wr),
		.rsp_wr_addr(rsp_wr_addr), .rsp_wr_data(rsp_wr_data), .rsp_ci(rsp_ci), .rsp_next(1'b0),
		.rx_frame(rx_frame), .rx_c(rx_c), .rx_ci(rx_ci), .rx_nbytes(rx_nbytes),
		.rx_mode_msb(rx_mode_msb), .rx_err(rx_err), .nke_seen(nke_seen), .fcb_expect(fcb_expect),
		.rsp_is_repeat(rsp_is_repeat), .rx_data_vld(rx_data_vld), .rx_data(rx_data));

	mbl_master_model #(.BIT(BIT)) MST (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));

	// ==========================================
	// telegram builders
	function automatic mbl_bq_t shortf(input logic [7:0] c, input logic [7:0] a);
		return '{8'h10, c, a, 8'(c + a), 8'h16};
	endfunction

	function automatic mbl_bq_t longf(input logic [7:0] c, a, ci, input mbl_bq_t u);
		mbl_bq_t t;
		logic [7:0] s;
		s = 8'(c + a + ci);
		foreach (u[i]) s = 8'(s + u[i]);
		t = '{8'h68, 8'(u.size() + 3), 8'(u.size() + 3), 8'h68, c, a, ci};
		t = {t, u, s, 8'h16};
		return t;
	endfunction

	// ==========================================
	// compares and closing
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk1(input string what, input logic exp, input logic got);
		chk8(what, {7'h00, exp}, {7'h00, got});
	endtask

	task automatic chkq(input string what, input mbl_bq_t exp, input mbl_bq_t got);
		chk8({what, " length"}, 8'(exp.size()), 8'(got.size()));
		foreach (exp[i]) if (i < got.size()) chk8(what, exp[i], got[i]);
	endtask

	task automatic wrap_up;
		fails += MST.errs;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// one request and whatever comes back; the master never talks over a reply
	task automatic xfer(input mbl_bq_t t, input int bad, output mbl_bq_t rep);
		int n;
		clr_caps = 1'b1;
		MST.tick(1);
		clr_caps = 1'b0;
		MST.send(t, bad);
		MST.recv(rep);
		n = 0;
		while (tx_busy !== 1'b0 && n < 200) begin
			MST.tick(1);
			n++;
		end
		if (n == 200) begin
			fails++;
			wrap_up();
		end
	endtask

	// ==========================================
	// main sequence
	initial begin
		{sec_selected, rsp_wr, rsp_wr_addr, rsp_wr_data} = '0;
		own_addr = 8'h05;
		rsp_len = 8'h03;
		rsp_ci = 8'h72;
		repeat (3) @(posedge ref_clk);
		#1 rst = 1'b0;
		// reply buffer: strobe held high across the burst
		rsp = '{8'h11, 8'h22, 8'h33};
		rsp_wr = 1'b1;
		foreach (rsp[i]) begin
			rsp_wr_addr = 8'(i);
			rsp_wr_data = rsp[i];
			MST.tick(1);
		end
		rsp_wr = 1'b0;
		rsp = longf(8'h08, 8'h05, 8'h72, rsp);
		// reset of the link answered by one ack character
		xfer(shortf(8'h40, 8'h05), -1, r);
		chkq("nke reply", '{8'he5}, r);
		chk1("nke seen", 1'b1, got_nke);
		chk1("fcb after nke", 1'b1, fcb_expect);
		// user data with most significant byte first mode
		d = '{8'ha1, 8'hb2};
		xfer(longf(8'h73, 8'h05, 8'h55, d), -1, r);
		chkq("snd_ud reply", '{8'he5}, r);
		chk8("c field", 8'h73, rx_c);
		chk8("ci field", 8'h55, rx_ci);
		chk8("user count", 8'h02, rx_nbytes);
		chk1("msb mode", 1'b1, rx_mode_msb);
		chkq("user data", d, rxq);
		chk1("fcb toggled", 1'b0, fcb_expect);
		// fresh request then the identical retry
		for (int k = 0; k < 2; k++) begin
			xfer(shortf(8'h5b, 8'h05), -1, r);
			chkq("rsp_ud reply", rsp, r);
			chk1("repeat flag", k[0], rsp_is_repeat);
			// a changed reply source must not leak into the retry
			rsp_ci = k[0] ? 8'h72 : 8'h7a;
			rsp_len = k[0] ? 8'h03 : 8'h02;
		end
		// frame count not valid: counting left alone
		xfer(shortf(8'h4b, 8'h05), -1, r);
		chkq("fcv clear reply", rsp, r);
		chk1("fcb ignored", 1'b1, fcb_expect);
		// other, broadcast, test and selected addresses
		foreach (atab[i]) begin
			sec_selected = atab[i][2];
			xfer(shortf(8'h4b, atab[i][10:3]), -1, r);
			chk1("frame accepted", atab[i][0], got_frame);
			if (atab[i][1]) chkq("address reply", rsp, r);
			else chkq("address silent", none, r);
		end
		sec_selected = 1'b0;
		// unconfigured slave answers at zero
		own_addr = 8'h00;
		xfer(shortf(8'h40, 8'h00), -1, r);
		chkq("addr zero reply", '{8'he5}, r);
		own_addr = 8'h05;
		// longest user data field
		d = {};
		for (int k = 0; k < 252; k++) d.push_back(8'(k));
		xfer(longf(8'h73, 8'h05, 8'h51, d), -1, r);
		chkq("long reply", '{8'he5}, r);
		chk8("long count", 8'hfc, rx_nbytes);
		chk1("lsb mode", 1'b0, rx_mode_msb);
		chkq("long data", d, rxq);
		// damaged telegrams: checksum, length pair, second start, end, parity
		d = '{8'ha1, 8'hb2};
		for (int k = 0; k < 5; k++) begin
			q = longf(8'h53, 8'h05, 8'h51, d);
			case (k)
				0: q[9] = q[9] ^ 8'h01;
				1: q[2] = 8'h06;
				2: q[3] = 8'h69;
				3: q[10] = 8'h17;
				default: q[0] = 8'h68;
			endcase
			xfer(q, (k == 4) ? 5 : -1, r);
			chkq("bad frame silent", none, r);
			chk1("bad frame flagged", 1'b1, got_err);
			chk1("bad frame dropped", 1'b0, got_frame);
		end
		// the count bit was left at zero above; a link reset brings it back to one
		xfer(shortf(8'h40, 8'h05), -1, r);
		chkq("nke again reply", '{8'he5}, r);
		chk1("fcb resync", 1'b1, fcb_expect);
		wrap_up();
	end
endmodule
